// ---- prot_defines.svh ----
// prot_defines.svh: offsets, bit positions and timing counts of the protection manager
// assumes: included by its bare name from every file that needs the numbers
`ifndef PROT_DEFINES_SVH
`define PROT_DEFINES_SVH
`define STATUS_OFFSET 8'h16
`define BIT_TEMP_WARN 7
`define BIT_POWER_GOOD 6
`define BIT_OVERVOLT 1
`define STATUS_RESERVED_VAL 1'b1
`define CLK_FREQ_KHZ 200000
`define RETRY_TIME_MS 130
`define RETRY_CYCLES (`RETRY_TIME_MS * `CLK_FREQ_KHZ)
`define TRACK_WINDOW_MV 250
`define OV_MARGIN_MV 250
`define OV_FLOOR_MV 500
`define OV_PCT_MIN 110
`define OV_PCT_MAX 130
`define PCT_DIV 100
`endif

// ---- prot_pkg.sv ----
// prot_pkg.sv: types shared by the protection manager and its fault line port
// assumes: nothing beyond a SystemVerilog compiler
package prot_pkg;
  typedef enum logic [1:0] {STYLE_SEQ, STYLE_CRIT, STYLE_EMER} off_style_t;
  typedef enum logic [1:0] {PW_OFF, PW_RUN, PW_SHUT} power_state_t;
  typedef enum logic [1:0] {LN_IDLE, LN_BIT1, LN_BIT0, LN_HOLD} line_state_t;
endpackage

// ---- retry_timer.sv ----
// retry_timer.sv: one-shot interval timer that holds off restarts after a trip
// assumes: start is a one-cycle pulse; busy stays high for CYCLES cycles after it
`timescale 1ns/1ps
`include "prot_defines.svh"
module retry_timer #(
  parameter int unsigned CYCLES = `RETRY_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic start, // restart the interval
  output logic busy // interval still running
);
  logic [31:0] cnt_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 32'h0;
      busy <= 1'b0;
    end else if (start) begin
      cnt_q <= 32'(CYCLES - 1);
      busy <= 1'b1;
    end else if (busy) begin
      if (cnt_q == 32'h0) begin
        busy <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 32'h1;
      end
    end
  end
endmodule

// ---- fault_line_port.sv ----
// fault_line_port.sv: drives and decodes the shared open-drain fault line
// assumes: sync_line and line_in are synchronous to clk; line moves on sync falls only
`timescale 1ns/1ps
module fault_line_port (
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic sync_line, // manager's synchronisation line
  input wire logic tx_req, // own fault wants the line low
  input prot_pkg::off_style_t tx_style, // turn-off style to send
  input wire logic line_in, // level seen on the fault line
  output logic line_out, // level driven when enabled
  output logic line_oe_b, // low while pulling the line
  output logic rx_fault, // a decoded fault is on the line
  output prot_pkg::off_style_t rx_style // decoded turn-off style
);
  import prot_pkg::*;
  logic sync_d_q, line_hi_q, rx_b1_q, sync_fall;
  line_state_t tx_q, rx_q;

  assign sync_fall = sync_d_q & !sync_line;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_d_q <= 1'b1;
      line_out <= 1'b0;
    end else begin
      sync_d_q <= sync_line;
      line_out <= 1'b0;
    end
  end

  // start low, then style bit 1, bit 0, then hold low while the fault lasts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_q <= LN_IDLE;
      line_oe_b <= 1'b1;
    end else if (sync_fall) begin // [RL21]
      case (tx_q)
        LN_IDLE: if (tx_req) begin
          line_oe_b <= 1'b0; // [RL16]
          tx_q <= LN_BIT1;
        end
        LN_BIT1: begin
          line_oe_b <= tx_style[1]; // [RL18]
          tx_q <= LN_BIT0;
        end
        LN_BIT0: begin
          line_oe_b <= tx_style[0]; // [RL18]
          tx_q <= LN_HOLD;
        end
        LN_HOLD: begin
          line_oe_b <= !tx_req;
          if (!tx_req) tx_q <= LN_IDLE;
        end
        default: tx_q <= LN_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_q <= LN_IDLE;
      line_hi_q <= 1'b1;
      rx_b1_q <= 1'b0;
      rx_fault <= 1'b0;
      rx_style <= STYLE_SEQ;
    end else if (sync_fall) begin
      line_hi_q <= line_in;
      case (rx_q)
        LN_IDLE: if (line_hi_q && !line_in) rx_q <= LN_BIT1;
        LN_BIT1: begin
          rx_b1_q <= line_in;
          rx_q <= LN_BIT0;
        end
        LN_BIT0: begin
          if (rx_b1_q) rx_style <= line_in ? STYLE_CRIT : STYLE_EMER;
          else rx_style <= line_in ? STYLE_CRIT : STYLE_SEQ;
          rx_fault <= 1'b1; // [RL18]
          rx_q <= LN_HOLD;
        end
        LN_HOLD: if (line_in) begin
          rx_fault <= 1'b0;
          rx_q <= LN_IDLE;
        end
        default: rx_q <= LN_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  line_on_sync_a: assert property ($changed(line_oe_b) |-> $past(sync_fall)) // [RL21]
    else $error("fault line moved without a sync falling edge");
  style_bit_a: assert property (tx_q == LN_BIT1 && sync_fall |=> // [RL18]
    line_oe_b == $past(tx_style[1])) else $error("style bit not sent on fault line");
endmodule

// ---- pol_fault_protection_manager.sv ----
// pol_fault_protection_manager.sv: fault detection, turn-off, hiccup and status of one converter
// assumes: voltages in mV and comparator flags arrive synchronous to clk
//
// Summary of operation
// (RL1) output above ov limit: error, off, flag
// (RL2) ov emergency: high side off, low on
// (RL3) ov limit 110..130 percent, floor 0.5V
// (RL4) ov limit at least 0.25V above setpoint
// (RL5) limits scale with present output target
// (RL6) margining never re-arms tracking protection
// (RL7) non-latching faults retry every 130ms
// (RL8) latched faults restart only after clear, cycle
// (RL9) retry interval independent of turn-off delay
// (RL10) separate turn-off style for ot, uv, ov
// (RL11) sequenced off uses normal ramp-down
// (RL12) critical off opens both switches at once
// (RL13) status bit layout, bit 0 reserved
// (RL14) active condition reads as 0
// (RL15) writing 1 clears latched fault
// (RL16) propagating fault pulls fault line low
// (RL17) line pulled low: turn off same style
// (RL18) style encoded at line falling edge
// (RL19) manager forwards style unchanged between groups
// (RL20) manager may cut front end, crowbar
// (RL21) fault line changes on sync falls only
// (RL22) tracking only in ramp-up, 250mV window
// (RL23) latched flag stays 0 until written
`timescale 1ns/1ps
`include "prot_defines.svh"
module pol_fault_protection_manager #(
  parameter int unsigned RETRY_CYCLES = `RETRY_CYCLES // hiccup interval in clk cycles
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // async power-on reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic reg_wr, // register write strobe
  input wire logic [7:0] reg_wdata, // register write data
  output logic [7:0] reg_rdata_q, // registered read data
  input wire logic on_cmd, // turn-on command
  input wire logic [12:0] vout_mv, // measured output
  input wire logic [12:0] target_mv, // present output target
  input wire logic [12:0] ramp_mv, // programmed ramp value
  input wire logic [7:0] ov_pct, // ov limit, percent
  input wire logic [7:0] uv_pct, // uv limit, percent
  input wire logic above_prebias, // output above pre-bias
  input wire logic steady_state, // ramp finished
  input wire logic ramping_up, // output ramping up
  input wire logic margin_change, // target moving by margining
  input wire logic track_en, // tracking protection enabled
  input wire logic oc_det, // overcurrent comparator
  input wire logic ot_det, // overtemperature comparator
  input wire logic tw_warn, // temperature warning active
  input wire logic pg_warn, // power-good warning active
  input wire logic [4:0] latch_cfg, // latching per fault: tr ot oc uv ov
  input wire logic [4:0] prop_cfg, // propagation per fault: tr ot oc uv ov
  input wire logic ot_style_crit, // ot off critical, else sequenced
  input wire logic uv_style_crit, // uv off critical, else sequenced
  input wire logic ov_style_emer, // ov off emergency, else critical
  input wire logic ramp_down_done, // sequenced ramp-down finished
  input wire logic sync_line, // manager's synchronisation line
  input wire logic fault_line_in, // shared fault line level
  output logic fault_line_out, // fault line drive level
  output logic fault_line_oe_b, // low while pulling the fault line
  output logic conv_on_q, // converter switching
  output logic hs_off_q, // high-side switch forced off
  output logic ls_on_q, // low-side switch forced on
  output logic ramp_down_q // controlled ramp-down request
);
  import prot_pkg::*;
  localparam logic [7:0] STATUS_ADDR = `STATUS_OFFSET;

  logic [13:0] ov_thr, uv_thr, pct_thr, trk_diff;
  logic [7:0] ov_pct_c, status;
  logic [4:0] cond, fault_q, clr;
  logic ov_det, uv_det, oc_act, trk_det, trip, remote, status_sel;
  logic timer_busy, timer_start, start_ok, latched_pend;
  logic track_armed_q, cycled_q, tx_req_q, rx_fault;
  off_style_t style, style_q, rx_style;
  power_state_t state_q;

  // limits follow the present target, so margining moves them too
  always_comb begin
    ov_pct_c = ov_pct;
    if (ov_pct < 8'(`OV_PCT_MIN)) ov_pct_c = 8'(`OV_PCT_MIN); // [RL3]
    if (ov_pct > 8'(`OV_PCT_MAX)) ov_pct_c = 8'(`OV_PCT_MAX); // [RL3]
    pct_thr = 14'((21'(target_mv) * 21'(ov_pct_c)) / 21'(`PCT_DIV)); // [RL5]
    ov_thr = pct_thr;
    if (ov_thr < 14'(target_mv) + 14'(`OV_MARGIN_MV)) begin
      ov_thr = 14'(target_mv) + 14'(`OV_MARGIN_MV); // [RL4]
    end
    if (ov_thr < 14'(`OV_FLOOR_MV)) ov_thr = 14'(`OV_FLOOR_MV); // [RL3]
    uv_thr = 14'((21'(target_mv) * 21'(uv_pct)) / 21'(`PCT_DIV)); // [RL5]
    if (vout_mv > ramp_mv) trk_diff = 14'(vout_mv - ramp_mv);
    else trk_diff = 14'(ramp_mv - vout_mv);
  end

  assign ov_det = above_prebias & ({1'b0, vout_mv} > ov_thr); // [RL1]
  assign uv_det = steady_state & conv_on_q & !oc_det & ({1'b0, vout_mv} < uv_thr);
  assign oc_act = above_prebias & oc_det;
  assign trk_det = track_en & ramping_up & track_armed_q &
    (trk_diff > 14'(`TRACK_WINDOW_MV)); // [RL22]
  assign cond = {trk_det, ot_det, oc_act, uv_det, ov_det};
  assign trip = |cond;
  assign remote = rx_fault & !tx_req_q; // [RL17]
  assign status_sel = (reg_addr == STATUS_ADDR);
  assign clr = (reg_wr && status_sel) ? reg_wdata[5:1] : 5'h00; // [RL15]
  assign status = {!tw_warn, !pg_warn, ~fault_q, `STATUS_RESERVED_VAL}; // [RL13] [RL14]
  assign latched_pend = |(fault_q & latch_cfg);
  assign start_ok = on_cmd & !timer_busy & !trip & !remote &
    (!latched_pend | cycled_q); // [RL8]
  assign timer_start = (state_q == PW_RUN) & (trip | remote); // [RL9]

  // one flag per fault; a new event wins over a clear in the same cycle
  for (genvar i = 0; i < 5; i++) begin : g_flag
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        fault_q[i] <= 1'b0;
      end else if (cond[i]) begin
        fault_q[i] <= 1'b1; // [RL1]
      end else if (clr[i] || !latch_cfg[i]) begin
        fault_q[i] <= 1'b0; // [RL23]
      end
    end
  end

  // style of the first active event in the order ov, oc or tracking, ot, uv; otherwise the style seen on the line
  always_comb begin
    if (cond[0]) style = ov_style_emer ? STYLE_EMER : STYLE_CRIT; // [RL10]
    else if (cond[2] || cond[4]) style = STYLE_CRIT;
    else if (cond[3]) style = ot_style_crit ? STYLE_CRIT : STYLE_SEQ; // [RL10]
    else if (cond[1]) style = uv_style_crit ? STYLE_CRIT : STYLE_SEQ; // [RL10]
    else style = rx_style; // [RL17]
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      track_armed_q <= 1'b0;
    end else if (margin_change || steady_state) begin
      track_armed_q <= 1'b0; // [RL6]
    end else if (state_q == PW_OFF && start_ok) begin
      track_armed_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_req_q <= 1'b0;
      reg_rdata_q <= 8'h00;
    end else begin
      tx_req_q <= |(fault_q & prop_cfg); // [RL16]
      reg_rdata_q <= status_sel ? status : 8'h00; // [RL14]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= PW_OFF;
      conv_on_q <= 1'b0;
      hs_off_q <= 1'b1;
      ls_on_q <= 1'b0;
      ramp_down_q <= 1'b0;
      style_q <= STYLE_SEQ;
      cycled_q <= 1'b0;
    end else begin
      case (state_q)
        PW_OFF: begin
          if (!on_cmd) cycled_q <= 1'b1;
          if (start_ok) begin // [RL7]
            state_q <= PW_RUN;
            conv_on_q <= 1'b1;
            hs_off_q <= 1'b0;
            ls_on_q <= 1'b0;
            cycled_q <= 1'b0;
          end
        end
        PW_RUN, PW_SHUT: begin
          if (trip || remote) begin
            style_q <= style;
            cycled_q <= 1'b0;
            // a lasting cause must not stall a sequenced ramp that has finished
            if (style == STYLE_SEQ && !(state_q == PW_SHUT && ramp_down_done)) begin
              state_q <= PW_SHUT;
              ramp_down_q <= 1'b1; // [RL11]
            end else begin
              state_q <= PW_OFF;
              conv_on_q <= 1'b0;
              ramp_down_q <= 1'b0;
              hs_off_q <= 1'b1; // [RL12]
              ls_on_q <= (style == STYLE_EMER); // [RL2]
            end
          end else if (state_q == PW_RUN && !on_cmd) begin
            state_q <= PW_SHUT;
            ramp_down_q <= 1'b1;
          end else if (state_q == PW_SHUT && ramp_down_done) begin
            state_q <= PW_OFF;
            conv_on_q <= 1'b0;
            ramp_down_q <= 1'b0;
            hs_off_q <= 1'b1;
          end
        end
        default: state_q <= PW_OFF;
      endcase
    end
  end

  retry_timer #(
    .CYCLES(RETRY_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .start(timer_start),
    .busy(timer_busy)
  );

  fault_line_port u_line (
    .clk(clk),
    .rst_b(rst_b),
    .sync_line(sync_line),
    .tx_req(tx_req_q),
    .tx_style(style_q),
    .line_in(fault_line_in),
    .line_out(fault_line_out),
    .line_oe_b(fault_line_oe_b),
    .rx_fault(rx_fault),
    .rx_style(rx_style)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence run_trip_s(off_style_t s);
    state_q == PW_RUN && trip && style == s;
  endsequence

  ov_trip_a: assert property (ov_det |=> fault_q[0] && !status[`BIT_OVERVOLT]) // [RL1]
    else $error("overvoltage not flagged");
  ov_emer_a: assert property (state_q == PW_RUN && ov_det && ov_style_emer |=> // [RL2]
    hs_off_q && ls_on_q && !conv_on_q) else $error("emergency off not applied");
  ov_limit_a: assert property (ov_thr >= 14'(`OV_FLOOR_MV) && // [RL3] [RL4]
    ov_thr >= 14'(target_mv) + 14'(`OV_MARGIN_MV)) else $error("ov limit too low");
  track_margin_a: assert property (margin_change |=> !track_armed_q) // [RL6]
    else $error("tracking armed during margining");
  retry_gap_a: assert property ($rose(conv_on_q) |-> !$past(timer_busy)) // [RL7] [RL9]
    else $error("restart inside hiccup interval");
  track_trip_a: assert property (state_q == PW_RUN && trk_det && !ov_det |=> // [RL22]
    !conv_on_q && hs_off_q && !ls_on_q) else $error("tracking trip not applied");
  oc_status_a: assert property (cond[2] |=> !status[3]) // [RL14]
    else $error("overcurrent flag not low");
  seq_off_a: assert property (run_trip_s(STYLE_SEQ) |=> // [RL11]
    ramp_down_q && conv_on_q && !hs_off_q) else $error("sequenced off not ramping");
  crit_off_a: assert property (run_trip_s(STYLE_CRIT) |=> // [RL12]
    hs_off_q && !ls_on_q && !conv_on_q) else $error("critical off not applied");
  read_map_a: assert property (status_sel |=> reg_rdata_q == $past(status)) // [RL13]
    else $error("status read wrong");
  clear_flag_a: assert property (fault_q[0] && clr[0] && !cond[0] |=> !fault_q[0]) // [RL15]
    else $error("write of 1 did not clear");
  latch_hold_a: assert property (fault_q[1] && latch_cfg[1] && !clr[1] |=> fault_q[1]) // [RL23]
    else $error("latched flag dropped without a write");
  remote_off_a: assert property (state_q == PW_RUN && remote && !trip && // [RL17]
    rx_style == STYLE_CRIT |=> hs_off_q && !conv_on_q) else $error("line fault ignored");
endmodule

// ---- fault_line_partner.sv ----
// fault_line_partner.sv: sync source of the manager plus one peer converter on the fault line
// assumes: shares clk with the device; a released fault line reads high through its pull-up
`timescale 1ns/1ps
module fault_line_partner (
  input wire logic clk, // system clock
  input wire logic rst_b, // reset, active low
  input wire logic send, // peer has a propagating fault
  input prot_pkg::off_style_t style, // peer turn-off style
  input wire logic dut_out, // device drive level
  input wire logic dut_oe_b, // device pulls while low
  output logic sync_line, // manager sync
  output logic line // wired fault line level
);
  import prot_pkg::*;
  logic [1:0] div_q;
  logic sync_prev_q;
  logic peer_q;
  logic [1:0] phase_q;
  // wired-and of both open-drain drivers
  assign line = peer_q & (dut_oe_b | dut_out);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 2'h0;
      sync_line <= 1'b1;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) sync_line <= ~sync_line;
    end
  end
  // peer line moves one cycle after each sync fall
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_prev_q <= 1'b1;
      peer_q <= 1'b1;
      phase_q <= 2'h0;
    end else begin
      sync_prev_q <= sync_line;
      if (sync_prev_q && !sync_line) begin
        case (phase_q)
          2'h0: if (send) begin
            peer_q <= 1'b0;
            phase_q <= 2'h1;
          end
          2'h1: begin
            peer_q <= style[1];
            phase_q <= 2'h2;
          end
          2'h2: begin
            peer_q <= style[0];
            phase_q <= 2'h3;
          end
          default: begin
            peer_q <= !send;
            if (!send) phase_q <= 2'h0;
          end
        endcase
      end
    end
  end
endmodule

// ---- pol_fault_protection_manager_tb.sv ----
// pol_fault_protection_manager_tb.sv: pin-driven checks of trips, restarts and line; status read and cleared over the register port
// assumes: design and partner compiled before; retry interval shortened to RETRY cycles
`timescale 1ns/1ps
module pol_fault_protection_manager_tb;
  import prot_pkg::*;
  localparam int unsigned RETRY = 20;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, on_cmd = 1'b0, above_prebias = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q, ov_pct = 8'd110, uv_pct = 8'd90;
  logic [12:0] vout_mv = 13'd1000, target_mv = 13'd1000, ramp_mv = 13'd1000;
  logic steady_state = 1'b1, ramping_up = 1'b0, track_en = 1'b0, tw_warn = 1'b0, pg_warn = 1'b0;
  logic [4:0] latch_cfg = 5'h00, prop_cfg = 5'h00;
  logic ov_style_emer = 1'b0, ramp_down_done = 1'b1, peer_send = 1'b0, margin_change = 1'b0;
  logic sync_line, fault_line_in, fault_line_out, fault_line_oe_b;
  logic conv_on_q, hs_off_q, ls_on_q, ramp_down_q;
  off_style_t peer_style = STYLE_SEQ;
  int mismatches = 0, check_count = 0, n;
  initial forever #2.5 clk = ~clk;
  pol_fault_protection_manager #(.RETRY_CYCLES(RETRY)) i_pol_fault_protection_manager (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .on_cmd(on_cmd), .vout_mv(vout_mv), .target_mv(target_mv),
    .ramp_mv(ramp_mv), .ov_pct(ov_pct), .uv_pct(uv_pct), .above_prebias(above_prebias),
    .steady_state(steady_state), .ramping_up(ramping_up), .margin_change(margin_change),
    .track_en(track_en), .oc_det(1'b0), .ot_det(1'b0), .tw_warn(tw_warn), .pg_warn(pg_warn),
    .latch_cfg(latch_cfg), .prop_cfg(prop_cfg), .ot_style_crit(1'b0), .uv_style_crit(1'b0),
    .ov_style_emer(ov_style_emer), .ramp_down_done(ramp_down_done), .sync_line(sync_line),
    .fault_line_in(fault_line_in), .fault_line_out(fault_line_out),
    .fault_line_oe_b(fault_line_oe_b), .conv_on_q(conv_on_q), .hs_off_q(hs_off_q),
    .ls_on_q(ls_on_q), .ramp_down_q(ramp_down_q));
  fault_line_partner i_fault_line_partner (.clk(clk), .rst_b(rst_b), .send(peer_send),
    .style(peer_style), .dut_out(fault_line_out), .dut_oe_b(fault_line_oe_b),
    .sync_line(sync_line), .line(fault_line_in));
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: return conv_on_q;
      default: return fault_line_oe_b;
    endcase
  endfunction
  // bounded wait on an output, sampled mid-cycle
  task automatic wait_sig(input int sel, input logic val, input int bound, output int k);
    k = 0;
    while (pick(sel) !== val) begin
      @(negedge clk);
      k++;
      if (k > bound) begin
        chk("wait", 8'h00, 8'h01);
        close_out();
      end
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    settle(2);
    chk("rdata", reg_rdata_q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  initial begin
    settle(16);
    rst_b <= 1'b1;
    settle(1);
    chk("reset", {ramp_down_q, ls_on_q, hs_off_q, conv_on_q, fault_line_oe_b, 3'h0}, 8'h28);
    on_cmd <= 1'b1;
    wait_sig(0, 1'b1, 10, n);
    rd_chk(8'h16, 8'hff);
    rd_chk(8'h25, 8'h00);
    tw_warn <= 1'b1;
    pg_warn <= 1'b1;
    rd_chk(8'h16, 8'h3f);
    tw_warn <= 1'b0;
    pg_warn <= 1'b0;
    // limits follow the target and the programmed percentage
    target_mv <= 13'd2000;
    vout_mv <= 13'd2350;
    ov_pct <= 8'd120;
    settle(6);
    chk("on", conv_on_q, 8'h01);
    ov_pct <= 8'd110;
    settle(2);
    chk("crit", {conv_on_q, hs_off_q, ls_on_q}, 8'h02);
    target_mv <= 13'd1000;
    vout_mv <= 13'd1000;
    wait_sig(0, 1'b1, RETRY + 10, n);
    chk("retry", n >= RETRY - 4 && n <= RETRY + 2, 8'h01);
    rd_chk(8'h16, 8'hff);
    // latched emergency trip with propagation
    latch_cfg <= 5'h01;
    prop_cfg <= 5'h01;
    ov_style_emer <= 1'b1;
    vout_mv <= 13'd1200;
    settle(6);
    chk("on", conv_on_q, 8'h01);
    above_prebias <= 1'b0;
    vout_mv <= 13'd1300;
    settle(6);
    chk("on", conv_on_q, 8'h01);
    above_prebias <= 1'b1;
    settle(2);
    chk("emer", {conv_on_q, hs_off_q, ls_on_q}, 8'h03);
    vout_mv <= 13'd1000;
    wait_sig(1, 1'b0, 40, n);
    chk("line", fault_line_out, 8'h00);
    rd_chk(8'h16, 8'hfd);
    settle(RETRY + 10);
    chk("on", conv_on_q, 8'h00);
    wr(8'h25, 8'h02);
    rd_chk(8'h16, 8'hfd);
    wr(8'h16, 8'h02);
    rd_chk(8'h16, 8'hff);
    wait_sig(0, 1'b1, 40, n);
    wait_sig(1, 1'b1, 40, n);
    latch_cfg <= 5'h00;
    prop_cfg <= 5'h00;
    ov_style_emer <= 1'b0;
    // undervoltage trip with sequenced ramp-down
    ramp_down_done <= 1'b0;
    vout_mv <= 13'd950;
    settle(4);
    uv_pct <= 8'd96;
    settle(3);
    chk("seq", {conv_on_q, ramp_down_q}, 8'h03);
    rd_chk(8'h16, 8'hfb);
    ramp_down_done <= 1'b1;
    wait_sig(0, 1'b0, 10, n);
    uv_pct <= 8'd90;
    wait_sig(0, 1'b1, RETRY + 10, n);
    // peer faults in every turn-off style
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      peer_style <= off_style_t'(s);
      peer_send <= 1'b1;
      wait_sig(0, 1'b0, 200, n);
      chk("peer", {hs_off_q, ls_on_q}, {6'h00, 1'b1, s == 2});
      @(posedge clk);
      peer_send <= 1'b0;
      wait_sig(0, 1'b1, 300, n);
    end
    // tracking trip during ramp-up
    on_cmd <= 1'b0;
    steady_state <= 1'b0;
    ramping_up <= 1'b1;
    track_en <= 1'b1;
    wait_sig(0, 1'b0, 100, n);
    @(posedge clk);
    on_cmd <= 1'b1;
    wait_sig(0, 1'b1, RETRY + 10, n);
    vout_mv <= 13'd800;
    settle(4);
    chk("on", conv_on_q, 8'h01);
    margin_change <= 1'b1;
    settle(1);
    margin_change <= 1'b0;
    vout_mv <= 13'd700;
    settle(4);
    chk("margin", conv_on_q, 8'h01);
    on_cmd <= 1'b0;
    wait_sig(0, 1'b0, 100, n);
    @(posedge clk);
    on_cmd <= 1'b1;
    settle(4);
    chk("track", {conv_on_q, hs_off_q, ls_on_q}, 8'h02);
    rd_chk(8'h16, 8'hdf);
    close_out();
  end
endmodule
